// File: verilog/drc_device_reset_control.sv
// Purpose: Reset sources, blocking delays and reset-affected registers
// Assumes: All inputs synchronous to pclk
// Notes: presetn models power-on reset; reset_pin_n is the hardware reset pin
// How it works
// [R1] Power-on reset loads every register default
// [R2] Block access 250 us after power-on
// [R3] Start in power-down mode at 0x02
// [R4] Host should hardware reset before enabling
// [R5] Host resets after core supply drops
// [R6] Reset pin low 20 ns starts reset
// [R7] Hardware reset: defaults, then 250 us block
// [R8] Writing soft-reset bit starts software reset
// [R9] Software reset spares registers 0x00, 0x01
// [R10] Block access 100 ns after software reset
// [R11] Soft-reset bit clears itself after reset
//
// The APB register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module drc_device_reset_control #(
  parameter int LONG_CYC = drc_pkg::LONG_DELAY_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic reset_pin_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic comm_ready,
  output logic [7:0] power_down
);
  // ============================================================
  // State
  typedef enum {ST_BUSY_LONG, ST_BUSY_SHORT, ST_READY} drc_phase_type;
  drc_phase_type phase_ff, nxt_phase;
  logic [31:0] cnt_ff, nxt_cnt; // Blocking countdown
  logic [7:0] pin_cnt_ff, nxt_pin_cnt; // Reset pin low length
  logic [7:0] ifcfg0_ff, nxt_ifcfg0; // Spared by soft reset
  logic [7:0] ifcfg1_ff, nxt_ifcfg1; // Spared by soft reset
  logic [7:0] pwrdn_ff, nxt_pwrdn; // Power-down control
  logic [3:0] src_ff, nxt_src; // Last reset source flags
  logic [31:0] prdata_ff, nxt_prdata;
  logic pslverr_ff, nxt_pslverr;
  logic ready_ff, nxt_ready;
  logic pready_ff, nxt_pready;
  logic acc;
  logic hw_fire;
  logic [9:0] idx;

  assign acc = psel && penable && !pready_ff;
  assign idx = paddr[11:2];
  // Fires once the pin has been low the least time
  assign hw_fire = !reset_pin_n && (pin_cnt_ff == 8'(drc_pkg::PIN_LOW_CYC - 1)); // R6

  // ============================================================
  // Next-state logic
  always_comb begin
    nxt_phase = phase_ff;
    nxt_cnt = cnt_ff;
    nxt_ifcfg0 = ifcfg0_ff;
    nxt_ifcfg1 = ifcfg1_ff;
    nxt_pwrdn = pwrdn_ff;
    nxt_src = src_ff;
    nxt_prdata = 32'h0;
    nxt_pslverr = 1'b0;
    nxt_pready = 1'b0;
    // Count pin low time, saturating just past the threshold
    if (reset_pin_n) begin
      nxt_pin_cnt = 8'h00;
    end else if (pin_cnt_ff < 8'(drc_pkg::PIN_LOW_CYC)) begin
      nxt_pin_cnt = pin_cnt_ff + 8'h01;
    end else begin
      nxt_pin_cnt = pin_cnt_ff;
    end
    // Countdown of the blocking window
    case (phase_ff)
      ST_BUSY_LONG, ST_BUSY_SHORT: begin
        if (cnt_ff <= 32'h1) begin
          nxt_phase = ST_READY; // R2 R10
        end
        nxt_cnt = cnt_ff - 32'h1;
      end
      ST_READY: nxt_cnt = 32'h0;
      default: nxt_phase = ST_READY;
    endcase
    // Bus access; refused with an error while blocked
    if (acc) begin
      nxt_pready = 1'b1;
      if (phase_ff != ST_READY) begin
        nxt_pslverr = 1'b1; // R2 R7 R10
      end else if (pwrite) begin
        case (idx)
          10'(drc_pkg::IDX_IFCFG0): begin
            if (pwdata[drc_pkg::SOFT_RESET_BIT]) begin
              // Soft reset: spare 0x00/0x01, default the rest
              nxt_pwrdn = drc_pkg::PWRDN_RST; // R8 R9
              nxt_src = 4'h0;
              nxt_src[drc_pkg::ST_SW_BIT] = 1'b1;
              nxt_phase = ST_BUSY_SHORT;
              nxt_cnt = 32'(drc_pkg::SOFT_DELAY_CYC);
              // Request bit is never stored, so it reads back zero
              nxt_ifcfg0 = pwdata[7:0] & ~(8'h01 << drc_pkg::SOFT_RESET_BIT); // R11
            end else begin
              nxt_ifcfg0 = pwdata[7:0];
            end
          end
          10'(drc_pkg::IDX_IFCFG1): nxt_ifcfg1 = pwdata[7:0];
          10'(drc_pkg::IDX_PWRDN): nxt_pwrdn = pwdata[7:0];
          10'(drc_pkg::IDX_STATUS): nxt_pslverr = 1'b0; // Read only, write ignored
          default: nxt_pslverr = 1'b1;
        endcase
      end else begin
        case (idx)
          10'(drc_pkg::IDX_IFCFG0): nxt_prdata = {24'h0, ifcfg0_ff};
          10'(drc_pkg::IDX_IFCFG1): nxt_prdata = {24'h0, ifcfg1_ff};
          10'(drc_pkg::IDX_PWRDN): nxt_prdata = {24'h0, pwrdn_ff};
          // Status: bit 0 ready, bits 3:1 the source of the last reset
          // Source flag 0 is never set, so it is left out to keep power-on at bit 1
          10'(drc_pkg::IDX_STATUS): nxt_prdata = {28'h0, src_ff[3:1], phase_ff == ST_READY};
          default: nxt_pslverr = 1'b1;
        endcase
      end
    end
    // Hardware reset overrides bus and soft reset: ifcfg0_ff, ifcfg1_ff and pwrdn_ff back to default
    if (hw_fire) begin
      nxt_ifcfg0 = drc_pkg::IFCFG0_RST; // R7
      nxt_ifcfg1 = drc_pkg::IFCFG1_RST;
      nxt_pwrdn = drc_pkg::PWRDN_RST; // R3
      nxt_src = 4'h0;
      nxt_src[drc_pkg::ST_HW_BIT] = 1'b1;
      nxt_phase = ST_BUSY_LONG;
      nxt_cnt = 32'(LONG_CYC);
    end
    nxt_ready = (nxt_phase == ST_READY);
  end

  // ============================================================
  // Registers; presetn is the power-on reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= ST_BUSY_LONG; // R1 R2
      // Same length as the pin reset, so a shortened build shortens both
      cnt_ff <= 32'(LONG_CYC); // R2
      pin_cnt_ff <= 8'h00;
      ifcfg0_ff <= drc_pkg::IFCFG0_RST; // R1
      ifcfg1_ff <= drc_pkg::IFCFG1_RST;
      pwrdn_ff <= drc_pkg::PWRDN_RST; // R3
      src_ff <= 4'h2;
      prdata_ff <= 32'h0;
      pslverr_ff <= 1'b0;
      pready_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else if (clk_en) begin
      phase_ff <= nxt_phase;
      cnt_ff <= nxt_cnt;
      pin_cnt_ff <= nxt_pin_cnt;
      ifcfg0_ff <= nxt_ifcfg0;
      ifcfg1_ff <= nxt_ifcfg1;
      pwrdn_ff <= nxt_pwrdn;
      src_ff <= nxt_src;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
      pready_ff <= nxt_pready;
      ready_ff <= nxt_ready;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign comm_ready = ready_ff;
  assign power_down = pwrdn_ff;

  // ============================================================
  // Checks
  // Next-cycle (|=>) antecedents carry clk_en: a frozen cycle must not count as a step
  a_hw_defaults: assert property (@(posedge pclk) disable iff (!presetn) // R7
    clk_en && hw_fire |=> pwrdn_ff == drc_pkg::PWRDN_RST && !comm_ready
    && ifcfg0_ff == drc_pkg::IFCFG0_RST && ifcfg1_ff == drc_pkg::IFCFG1_RST)
    else $error("hardware reset did not default registers");
  // Power-on defaults must hold for the whole blocked window
  a_por_regs: assert property (@(posedge pclk) disable iff (!presetn) // R1
    phase_ff == ST_BUSY_LONG && src_ff[drc_pkg::ST_POR_BIT]
    |-> ifcfg0_ff == drc_pkg::IFCFG0_RST && ifcfg1_ff == drc_pkg::IFCFG1_RST)
    else $error("registers not at default after power-on");
  // A request write while open must start the short blocked window
  a_sw_start: assert property (@(posedge pclk) disable iff (!presetn) // R8
    clk_en && acc && pwrite && phase_ff == ST_READY && !hw_fire
    && idx == 10'(drc_pkg::IDX_IFCFG0) && pwdata[drc_pkg::SOFT_RESET_BIT]
    |=> phase_ff == ST_BUSY_SHORT && !comm_ready)
    else $error("soft reset request ignored");
  // A refused write must leave pwrdn_ff and ifcfg1_ff untouched
  a_busy_drop: assert property (@(posedge pclk) disable iff (!presetn) // R10
    clk_en && acc && pwrite && phase_ff != ST_READY && !hw_fire
    |=> pwrdn_ff == $past(pwrdn_ff) && ifcfg1_ff == $past(ifcfg1_ff))
    else $error("write landed while blocked");
  a_pin_short: assert property (@(posedge pclk) disable iff (!presetn) // R6
    clk_en && $rose(reset_pin_n) && pin_cnt_ff < 8'(drc_pkg::PIN_LOW_CYC) && comm_ready
    |=> comm_ready)
    else $error("short reset pin pulse caused reset");
  a_soft_spare: assert property (@(posedge pclk) disable iff (!presetn) // R9
    clk_en && !hw_fire && nxt_phase == ST_BUSY_SHORT && phase_ff == ST_READY && presetn
    |=> ifcfg1_ff == $past(ifcfg1_ff) && pwrdn_ff == drc_pkg::PWRDN_RST)
    else $error("soft reset touched spared register");
  a_soft_clear: assert property (@(posedge pclk) disable iff (!presetn) // R11
    !ifcfg0_ff[drc_pkg::SOFT_RESET_BIT])
    else $error("soft reset bit stuck");
  a_soft_block: assert property (@(posedge pclk) disable iff (!presetn) // R10
    phase_ff == ST_BUSY_SHORT |-> !comm_ready)
    else $error("ready while soft reset delay runs");
  a_busy_err: assert property (@(posedge pclk) disable iff (!presetn) // R2
    clk_en && acc && phase_ff != ST_READY |=> pready && pslverr)
    else $error("access not refused while blocked");
  a_apb_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && pready |=> !pready)
    else $error("pready held more than one cycle");
  a_pd_start: assert property (@(posedge pclk) disable iff (!presetn) // R3
    phase_ff == ST_BUSY_LONG && src_ff[drc_pkg::ST_POR_BIT] |-> pwrdn_ff == drc_pkg::PWRDN_RST)
    else $error("not in power-down after power-on");
endmodule // drc_device_reset_control
`default_nettype wire

// File: shared/drc_pkg.sv
// Purpose: Constants for the device reset control block
// Assumes: pclk at 250 MHz, APB with 32-bit data
// Notes: Offsets 0x0, 0x1, 0x2 are register indexes; byte address is index times four
// ============================================================
// Package
package drc_pkg;
  // Register indexes as printed
  localparam logic [7:0] IDX_IFCFG0 = 8'h00;
  localparam logic [7:0] IDX_IFCFG1 = 8'h01;
  localparam logic [7:0] IDX_PWRDN = 8'h02;
  localparam logic [7:0] IDX_STATUS = 8'h03;
  localparam logic [7:0] IDX_HWRST = 8'h04;
  // Field positions
  localparam int SOFT_RESET_BIT = 7;
  localparam int ST_READY_BIT = 0;
  localparam int ST_POR_BIT = 1;
  localparam int ST_HW_BIT = 2;
  localparam int ST_SW_BIT = 3;
  // Reset values
  localparam logic [7:0] IFCFG0_RST = 8'h00;
  localparam logic [7:0] IFCFG1_RST = 8'h00;
  localparam logic [7:0] PWRDN_RST = 8'hff;
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int LONG_DELAY_US = 250;
  localparam int SOFT_DELAY_NS = 100;
  localparam int PIN_LOW_NS = 20;
  localparam int LONG_DELAY_CYC = LONG_DELAY_US * CLK_MHZ;
  localparam int SOFT_DELAY_CYC = (SOFT_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int PIN_LOW_CYC = (PIN_LOW_NS * CLK_MHZ + 999) / 1000;
endpackage

// File: test/drc_host_model.sv
// Purpose: Host controller model that drives APB and the hardware reset pin
// Assumes: Tasks are called from one process at a time
// Notes: Released address and data lines show the inverse of the last value, never a stale copy
`timescale 1ns/10ps
`default_nettype none
module drc_host_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic reset_pin_n,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic comm_ready
);
  // ============================================================
  // Idle bus and released reset pin from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    reset_pin_n = 1'b1;
  end
  // ============================================================
  // Bus transfer: request held until pready is sampled high
  // No own limit: only the bench timeout may end a hung wait
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
  // ============================================================
  // Pin reset: also the recovery path after a core supply dip
  task automatic pin_reset(input int cyc);
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    repeat (cyc) @(posedge pclk);
    reset_pin_n <= 1'b1;
  endtask
  // ============================================================
  // Stay quiet until the device says it listens again or 100000 cycles pass
  task automatic wait_ready(output int n);
    n = 0;
    while (comm_ready !== 1'b1 && n < 100000) begin
      @(posedge pclk);
      n++;
    end
  endtask
endmodule // drc_host_model
`default_nettype wire

// File: test/tb_top.sv
// Purpose: Self-checking bench for the device reset control block
// Assumes: LONG_CYC shortened to keep the run brief
// Notes: Register byte address is four times the register index
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int LONG = 20;
  localparam logic [11:0] A_C0 = 12'h000;
  localparam logic [11:0] A_C1 = 12'h004;
  localparam logic [11:0] A_PD = 12'h008;
  localparam logic [11:0] A_ST = 12'h00c;
  localparam logic [11:0] A_UN = 12'h010;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic reset_pin_n, psel, penable, pwrite, pready, pslverr, comm_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] power_down;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int n;
  drc_device_reset_control #(.LONG_CYC(LONG)) dut (.pclk, .presetn, .clk_en,
    .reset_pin_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .comm_ready, .power_down);
  drc_host_model host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
    .reset_pin_n, .prdata, .pready, .pslverr, .comm_ready);
  // ============================================================
  // Clock and hang guard
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // One access, judged on data (reads only) and on the error flag
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] ed, input logic ee);
    logic [31:0] rd;
    logic er;
    host.xfer(w, a, d, rd, er);
    if (!w) chk("prdata", ed, rd);
    chk("pslverr", {31'h0, ee}, {31'h0, er});
  endtask
  task automatic summarize;
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ============================================================
  // Scenarios
  task automatic t_por;
    chk("pd_in_reset", 32'h0000_00ff, {24'h0, power_down});
    presetn <= 1'b1;
    host.wait_ready(n);
    chk("por_wait_ok", 32'h1, {31'h0, n >= LONG - 1 && n <= LONG + 2});
    acc(1'b0, A_PD, 0, 32'h0000_00ff, 1'b0);
    acc(1'b0, A_C1, 0, 32'h0, 1'b0);
    acc(1'b0, A_ST, 0, 32'h3, 1'b0);
  endtask
  task automatic t_hw;
    acc(1'b1, A_C1, 32'h3c, 0, 1'b0);
    host.pin_reset(4);
    @(posedge pclk);
    chk("short_pulse", 32'h1, {31'h0, comm_ready});
    acc(1'b0, A_C1, 0, 32'h3c, 1'b0);
    host.pin_reset(5);
    @(posedge pclk);
    chk("hw_block", 32'h0, {31'h0, comm_ready});
    host.wait_ready(n);
    chk("hw_wait_ok", 32'h1, {31'h0, n >= LONG - 4 && n <= LONG + 2});
    acc(1'b0, A_C1, 0, 32'h0, 1'b0);
    acc(1'b0, A_ST, 0, 32'h5, 1'b0);
  endtask
  task automatic t_rw;
    acc(1'b1, A_PD, 32'h00, 0, 1'b0);
    chk("pd_port", 32'h0, {24'h0, power_down});
    acc(1'b0, A_UN, 0, 32'h0, 1'b1);
  endtask
  task automatic t_soft;
    acc(1'b1, A_C1, 32'h5a, 0, 1'b0);
    acc(1'b1, A_C0, 32'h85, 0, 1'b0);
    chk("sw_pd", 32'h0000_00ff, {24'h0, power_down});
    // Frozen clock enable must hold the blocked window where it is
    clk_en <= 1'b0;
    repeat (30) @(posedge pclk);
    clk_en <= 1'b1;
    chk("sw_freeze", 32'h0, {31'h0, comm_ready});
    acc(1'b1, A_PD, 32'h11, 0, 1'b1);
    host.wait_ready(n);
    chk("sw_wait_ok", 32'h1, {31'h0, n <= drc_pkg::SOFT_DELAY_CYC});
    acc(1'b0, A_C0, 0, 32'h05, 1'b0);
    acc(1'b0, A_C1, 0, 32'h5a, 1'b0);
    acc(1'b0, A_PD, 0, 32'h0000_00ff, 1'b0);
    acc(1'b0, A_ST, 0, 32'h9, 1'b0);
  endtask
  // ============================================================
  // Main sequence: six reset cycles, then each scenario in turn
  initial begin
    repeat (6) @(posedge pclk);
    t_por();
    t_hw();
    t_rw();
    t_soft();
    summarize();
  end
endmodule // tb_top
`default_nettype wire
